// >>> aab_axi_slave.sv
// axi4-lite responder model with programmable wait and a mute switch
module aab_axi_slave
#(
  parameter int AW = 10
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wait_cyc,
  input wire logic mute,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic [31:0] wdata,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic awready,
  output logic wready,
  output logic arready,
  output logic rvalid,
  output logic [31:0] rdata,
  output logic [AW-1:0] got_addr,
  output logic [31:0] got_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q;
  logic pend;
  logic hit;
  // a muted responder never answers, so the bridge has to time out
  assign pend = (awvalid && wvalid) || arvalid;
  assign hit = pend && !mute && cnt_q == wait_cyc;
  assign awready = hit && awvalid;
  assign wready = hit && wvalid;
  assign arready = hit && arvalid;
  // wait counter; read data follows the address handshake by one cycle
  always_ff @(posedge clk)
  begin
    cnt_q <= (rst || !pend || hit) ? 8'h00 : cnt_q + 8'h01;
    rvalid <= !rst && arready;
    rdata <= arready ? 32'hC35A0000 ^ 32'(araddr) : ~rdata; // idle data toggles
    if (awready)
      got_addr <= awaddr;
    if (arready)
      got_addr <= araddr;
    if (wready)
      got_wdata <= wdata;
  end
endmodule // aab_axi_slave

// >>> aab_bridge.sv
// apb3 target to axi4-lite initiator bridge, one transfer at a time
//
// Contract
// - take apb3 transfers as target and reissue each as one axi4-lite transaction
// - only one read or write in flight; nothing new until it ends
// - no axi completion within 128 cycles raises the apb error flag
// - apb data is 32 bits; address width parameter ranges 2 to 32
// - apb direction high means write, low means read
// - axi data is 32 bits; axi addresses match apb address width
// - axi read or write address is the held copy of apb address
// - axi read-data ready stays high from the first edge after reset
// - no-wait write ends with a one-cycle ready, four cycles after select
// - no-wait read ends with a one-cycle ready, three cycles after select
module aab_bridge
  import aab_pkg::*;
#(
  parameter int unsigned address_width_param = aab_pkg::AAB_ADDR_W_DEF
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [address_width_param-1:0] apb_paddr,
  input wire logic apb_target_select,
  input wire logic apb_penable,
  input wire logic apb_direction,
  input wire logic [aab_pkg::AAB_DATA_W-1:0] apb_pwdata,
  output logic apb_transfer_done,
  output logic [aab_pkg::AAB_DATA_W-1:0] apb_prdata,
  output logic apb_error_flag,
  input wire logic m_axi_awready,
  input wire logic m_axi_wready,
  input wire logic m_axi_arready,
  input wire logic [aab_pkg::AAB_DATA_W-1:0] m_axi_rdata,
  input wire logic m_axi_rvalid,
  output logic [address_width_param-1:0] m_axi_awaddr,
  output logic m_axi_awvalid,
  output logic [aab_pkg::AAB_DATA_W-1:0] m_axi_wdata,
  output logic m_axi_wvalid,
  output logic [address_width_param-1:0] m_axi_araddr,
  output logic m_axi_arvalid,
  output logic m_axi_rready
);
  import aab_pkg::*;

  // address width must stay in its legal range; a bad build trips this at the first edge
  a_addr_width: assert property (@(posedge clk)
    (address_width_param >= AAB_ADDR_W_MIN) && (address_width_param <= AAB_ADDR_W_MAX))
    else $error("address width out of range");

  aab_state_t state_q;
  aab_state_t state_d;
  logic [address_width_param-1:0] addr_q;
  logic [AAB_DATA_W-1:0] wdata_q;
  logic [AAB_DATA_W-1:0] rdata_q;
  logic awv_q;
  logic wv_q;
  logic arv_q;
  logic done_q;
  logic err_q;
  logic rr_q;
  logic awv_d;
  logic wv_d;
  logic arv_d;
  logic expired;

  // request decode; setup phase only recognised when idle
  wire req_start = (state_q == AAB_IDLE) && apb_target_select && !apb_penable;
  wire in_write = (state_q == AAB_WRITE);
  wire in_read = (state_q == AAB_READ);
  wire aw_hs = awv_q && m_axi_awready;
  wire w_hs = wv_q && m_axi_wready;
  wire ar_hs = arv_q && m_axi_arready;
  wire r_hs = in_read && !arv_q && m_axi_rvalid;
  // write ends once both address and data channels have handshaked
  wire wr_fin = in_write && (!awv_d) && (!wv_d);
  wire rd_fin = r_hs;
  wire waiting = in_write || in_read;
  // reads launch straight from idle, writes one setup cycle later
  wire rd_launch = req_start && !apb_direction;
  wire wr_launch = (state_q == AAB_SETUP);
  // a finished write spends one cycle in done so its ready lands a cycle after a read's would
  wire wr_settle = (state_q == AAB_DONE);
  wire answer = expired || rd_fin || wr_settle;

  // valid flags drop on their handshake or on timeout
  assign awv_d = awv_q && !aw_hs && !expired;
  assign wv_d = wv_q && !w_hs && !expired;
  assign arv_d = arv_q && !ar_hs && !expired;

  aab_wdog u_wdog (
    .clk(clk),
    .rst(rst),
    .run(waiting),
    .expired(expired)
  );

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      AAB_IDLE:
      begin
        if (req_start)
        begin
          // direction picks the channel set; reads skip the setup cycle
          state_d = apb_direction ? AAB_SETUP : AAB_READ;
        end
      end
      AAB_SETUP:
      begin
        state_d = AAB_WRITE;
      end
      AAB_WRITE:
      begin
        if (expired)
        begin
          state_d = AAB_IDLE;
        end
        else if (wr_fin)
        begin
          state_d = AAB_DONE;
        end
      end
      AAB_READ:
      begin
        if (expired || rd_fin)
        begin
          state_d = AAB_IDLE;
        end
      end
      AAB_DONE:
      begin
        state_d = AAB_IDLE;
      end
      default:
      begin
        state_d = AAB_IDLE;
      end
    endcase
  end

  // state and handshake flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= AAB_IDLE;
      awv_q <= 1'b0;
      wv_q <= 1'b0;
      arv_q <= 1'b0;
      rr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      rr_q <= 1'b1;
      awv_q <= wr_launch || awv_d;
      wv_q <= wr_launch || wv_d;
      arv_q <= rd_launch || arv_d;
    end
  end

  // held copies of the apb request, captured in the setup cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_q <= '0;
      wdata_q <= AAB_DATA_ZERO;
    end
    else if (req_start)
    begin
      addr_q <= apb_paddr;
      wdata_q <= apb_pwdata;
    end
  end

  // apb answer: one-cycle ready, error only on timeout
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= AAB_DATA_ZERO;
    end
    else
    begin
      done_q <= answer;
      err_q <= expired;
      if (rd_fin)
      begin
        rdata_q <= m_axi_rdata;
      end
    end
  end

  assign apb_transfer_done = done_q;
  assign apb_error_flag = err_q;
  assign apb_prdata = rdata_q;
  assign m_axi_awaddr = addr_q;
  assign m_axi_araddr = addr_q;
  assign m_axi_wdata = wdata_q;
  assign m_axi_awvalid = awv_q;
  assign m_axi_wvalid = wv_q;
  assign m_axi_arvalid = arv_q;
  assign m_axi_rready = rr_q;

  // no new axi request while a transfer is in flight
  a_one_in_flight: assert property (@(posedge clk) disable iff (rst)
    !((awv_q || wv_q) && arv_q))
    else $error("read and write valid together");

  // error flag always comes with ready
  a_error_ready: assert property (@(posedge clk) disable iff (rst)
    apb_error_flag |-> apb_transfer_done)
    else $error("error without ready");

  // timeout yields error one cycle later and drops valids
  a_timeout_err: assert property (@(posedge clk) disable iff (rst)
    expired |=> (apb_error_flag && !m_axi_awvalid && !m_axi_wvalid && !m_axi_arvalid))
    else $error("timeout did not flag error");

  // ready is a one-cycle pulse
  a_ready_pulse: assert property (@(posedge clk) disable iff (rst)
    apb_transfer_done |=> !apb_transfer_done)
    else $error("ready longer than one cycle");

  // read ready always high after reset
  a_rready_high: assert property (@(posedge clk) disable iff (rst)
    $past(!rst) |-> m_axi_rready)
    else $error("rready dropped");

  sequence s_rd_req;
    (state_q == AAB_IDLE) && apb_target_select && !apb_penable && !apb_direction;
  endsequence
  sequence s_wr_req;
    (state_q == AAB_IDLE) && apb_target_select && !apb_penable && apb_direction;
  endsequence

  // read: arvalid in the cycle after the setup cycle, address copied
  a_read_issue: assert property (@(posedge clk) disable iff (rst)
    s_rd_req |=> (m_axi_arvalid && m_axi_araddr == $past(apb_paddr)))
    else $error("read not issued");

  // write: both write valids two cycles after select
  a_write_issue: assert property (@(posedge clk) disable iff (rst)
    s_wr_req |=> ##1 (m_axi_awvalid && m_axi_wvalid && m_axi_wdata == $past(apb_pwdata, 2)))
    else $error("write not issued");

  // no-wait write answers within four cycles of setup
  a_write_quick: assert property (@(posedge clk) disable iff (rst)
    (s_wr_req ##1 1'b1 ##1 (m_axi_awready && m_axi_wready)) |=> ##1 apb_transfer_done)
    else $error("no-wait write late");
endmodule // aab_bridge

// >>> aab_pkg.sv
// package for the apb3 to axi4-lite bridge: widths, states, timing
package aab_pkg;
  localparam int unsigned AAB_DATA_W = 32;
  localparam int unsigned AAB_ADDR_W_MIN = 2;
  localparam int unsigned AAB_ADDR_W_MAX = 32;
  localparam int unsigned AAB_ADDR_W_DEF = 10;
  // clock rate and timeout (timeout is given in cycles)
  localparam int unsigned AAB_CLK_HZ = 20000000;
  localparam int unsigned AAB_TIMEOUT_CYC = 128;
  localparam int unsigned AAB_CNT_W = 8;
  localparam logic [AAB_CNT_W-1:0] AAB_CNT_ZERO = 8'h00;
  localparam logic [AAB_CNT_W-1:0] AAB_CNT_ONE = 8'h01;
  localparam logic [AAB_CNT_W-1:0] AAB_CNT_LAST = AAB_CNT_W'(AAB_TIMEOUT_CYC - 1);
  localparam logic [AAB_DATA_W-1:0] AAB_DATA_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    AAB_IDLE = 3'b000,
    AAB_SETUP = 3'b001,
    AAB_WRITE = 3'b010,
    AAB_READ = 3'b011,
    AAB_DONE = 3'b100
  } aab_state_t;
endpackage

// >>> aab_wdog.sv
// timeout counter for a pending axi transaction
module aab_wdog
  import aab_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic expired
);
  logic [AAB_CNT_W-1:0] cnt_q;
  logic [AAB_CNT_W-1:0] cnt_d;

  // counts while the transaction runs, clears when it stops
  assign cnt_d = run ? (cnt_q + AAB_CNT_ONE) : AAB_CNT_ZERO;
  // expires on the 128th waiting cycle
  assign expired = run && (cnt_q == AAB_CNT_LAST);

  // counter register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= AAB_CNT_ZERO;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end
endmodule // aab_wdog

// >>> test_aab_bridge.sv
// self-checking bench for the apb3 to axi4-lite bridge
module test_aab_bridge;
  import aab_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = 10;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] pa = '0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] pwd = '0;
  logic [7:0] wc = 8'h00;
  logic mute = 1'b0;
  logic done, err, awr, wr, arr, rv, awv, wv, arv, rrdy;
  logic [31:0] prd, rdat, wdat, gwd;
  logic [AW-1:0] awa, ara, gad;
  int n_fail = 0;
  int checks_done = 0;
  int nw, nr, n;
  logic e;
  always #25 clk = ~clk;
  aab_bridge #(.address_width_param(AW)) u_aab_bridge (.clk(clk), .rst(rst), .apb_paddr(pa),
    .apb_target_select(psel), .apb_penable(pen), .apb_direction(pwr), .apb_pwdata(pwd),
    .apb_transfer_done(done), .apb_prdata(prd), .apb_error_flag(err), .m_axi_awready(awr),
    .m_axi_wready(wr), .m_axi_arready(arr), .m_axi_rdata(rdat), .m_axi_rvalid(rv),
    .m_axi_awaddr(awa), .m_axi_awvalid(awv), .m_axi_wdata(wdat), .m_axi_wvalid(wv),
    .m_axi_araddr(ara), .m_axi_arvalid(arv), .m_axi_rready(rrdy));
  aab_axi_slave #(.AW(AW)) u_aab_axi_slave (.clk(clk), .rst(rst), .wait_cyc(wc), .mute(mute),
    .awaddr(awa), .awvalid(awv), .wvalid(wv), .wdata(wdat), .araddr(ara), .arvalid(arv),
    .awready(awr), .wready(wr), .arready(arr), .rvalid(rv), .rdata(rdat), .got_addr(gad),
    .got_wdata(gwd));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request is held until ready is seen
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [31:0] d,
    input logic [7:0] wt, input logic m, output int k, output logic ef);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    wc <= wt;
    mute <= m;
    @(posedge clk);
    pen <= 1'b1;
    k = 1;
    @(negedge clk);
    while (done !== 1'b1 && k < 300)
    begin
      k++;
      @(negedge clk);
    end
    ef = err;
    @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic sc_write();
    xfer(1'b1, 10'h155, 32'h1234ABCD, 8'h00, 1'b0, nw, e);
    check(nw, 32'd4);
    check(gad, 10'h155);
    check(gwd, 32'h1234ABCD);
    check(e, 1'b0);
    xfer(1'b1, 10'h2AA, 32'hFEDC0123, 8'h05, 1'b0, n, e);
    check(n, nw + 5);
    check(gwd, 32'hFEDC0123);
  endtask
  task automatic sc_read();
    xfer(1'b0, 10'h3C0, 32'h0, 8'h00, 1'b0, nr, e);
    check(nr, 32'd3);
    check(prd, 32'hC35A03C0);
    check(gad, 10'h3C0);
    check(awv, 1'b0);
    xfer(1'b0, 10'h03F, 32'h0, 8'h07, 1'b0, n, e);
    check(n, nr + 7);
    check(prd, 32'hC35A003F);
  endtask
  // longest recommended wait must still finish without error
  task automatic sc_limit();
    xfer(1'b0, 10'h001, 32'h0, 8'd123, 1'b0, n, e);
    check(n, nr + 123);
    check(e, 1'b0);
  endtask
  task automatic sc_timeout();
    xfer(1'b1, 10'h200, 32'hA5A5A5A5, 8'h00, 1'b1, n, e);
    check(e, 1'b1);
    check(n >= 128 && n <= 134, 1'b1);
    @(negedge clk);
    check({awv, wv, err}, 3'b000);
    check(rrdy, 1'b1);
    xfer(1'b0, 10'h0F0, 32'h0, 8'h00, 1'b0, n, e);
    check(n, nr);
    check(prd, 32'hC35A00F0);
  endtask
  task automatic results();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence: reset, then every scenario
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(rrdy, 1'b1);
    sc_write();
    sc_read();
    sc_limit();
    sc_timeout();
    results();
  end
  // a hang is cut short well past the expected run length
  initial
  begin
    repeat (3000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule // test_aab_bridge
